// ---- rtl/ssmc_pkg.sv ----
// constants, types and pin bundle of the serial sram mode control block
package ssmc_pkg;
    // command bytes
    localparam logic [7:0] SSMC_CMD_READ      = 8'h03;
    localparam logic [7:0] SSMC_CMD_WRITE     = 8'h02;
    localparam logic [7:0] SSMC_CMD_RD_CFG    = 8'h05;
    localparam logic [7:0] SSMC_CMD_WR_CFG    = 8'h01;
    localparam logic [7:0] SSMC_CMD_DUAL      = 8'h3b;
    localparam logic [7:0] SSMC_CMD_QUAD      = 8'h38;
    localparam logic [7:0] SSMC_CMD_RST_WIDTH = 8'hff;
    // transfer_config_register layout
    localparam int         SSMC_MODE_MSB      = 7;
    localparam int         SSMC_MODE_LSB      = 6;
    localparam logic [1:0] SSMC_MODE_BYTE     = 2'b00;
    localparam logic [1:0] SSMC_MODE_PAGE     = 2'b10;
    localparam logic [1:0] SSMC_MODE_SEQ      = 2'b01;
    localparam logic [7:0] SSMC_CFG_RESET     = 8'h40;
    localparam logic [5:0] SSMC_CFG_RSVD      = 6'h00;
    // phase lengths in bits; dummy clocks, page offset and address widths, sck period in ns
    localparam logic [4:0] SSMC_CMD_BITS      = 5'h08;
    localparam logic [4:0] SSMC_ADDR_BITS     = 5'h18;
    localparam logic [4:0] SSMC_DATA_BITS     = 5'h08;
    localparam int         SSMC_DUMMY_CLKS    = 4;
    localparam logic [4:0] SSMC_DUMMY_BITS    = 5'(SSMC_DUMMY_CLKS * 2);
    localparam int         SSMC_PAGE_BITS     = 5;
    localparam int         SSMC_ADDR_W        = 16;
    localparam int         SSMC_SCK_PERIOD_NS = 800;

    typedef enum logic [2:0] {
        SSMC_W1 = 3'b001,
        SSMC_W2 = 3'b010,
        SSMC_W4 = 3'b100
    } ssmc_width_t;

    typedef enum logic [7:0] {
        SSMC_IDLE  = 8'b0000_0001,
        SSMC_CMD   = 8'b0000_0010,
        SSMC_ADDR  = 8'b0000_0100,
        SSMC_DUMMY = 8'b0000_1000,
        SSMC_WDATA = 8'b0001_0000,
        SSMC_RDATA = 8'b0010_0000,
        SSMC_CFGW  = 8'b0100_0000,
        SSMC_SKIP  = 8'b1000_0000
    } ssmc_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] sio;
    } ssmc_pins_t;
endpackage

// ---- rtl/ssmc_serial_sram.sv ----
// serial sram device: command decode, config register, width switching
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// R01: command 05h shifts out the config register in any mode.
// R02: config bits 7:6 pick byte 00, page 10, sequential 01, 11 reserved.
// R03: the mode field comes up as sequential 01 after reset.
// R04: the host writes zeros into config bits 5:0.
// R05: command 01h is followed by one byte whose mode bits are stored.
// R06: command 3Bh switches to two bits per clock on lines zero and one.
// R07: command 38h switches to one nibble per clock on lines zero to three.
// R08: command FFh sent in the active width returns to single-bit width.
// R09: a dual-width read waits four dummy clocks before data comes out.
// R10: a dual-width write takes data right after the address.
// R11: a host reset alone must find the width and send FFh accordingly.
// R12: read 03h and write 02h carry a 24-bit address, top byte ignored, msb first.
// R13: page mode wraps within 32 bytes, sequential wraps at the array end.
// R14: raising chip select ends the current command.
// R15: in quad width the pause input is off and its pin is data line three.
// R16: config and width changes apply from the next chip select frame.
module ssmc_serial_sram
    import ssmc_pkg::*;
#(
    parameter int ADDR_W = SSMC_ADDR_W
)(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic [3:0] sio_in,
    output logic      [3:0] sio_out,
    output logic      [3:0] sio_oe
);
    import ssmc_pkg::*;

    logic [7:0]        mem [0:(1 << ADDR_W) - 1];
    ssmc_pins_t        pin_s1_ff, pin_s2_ff, pin_s3_ff;
    ssmc_state_t       state_ff, nxt_state;
    ssmc_width_t       width_ff, nxt_width, pend_width_ff, nxt_pend_width;
    logic [4:0]        cnt_ff, nxt_cnt;
    logic [23:0]       in_sr_ff, nxt_in_sr;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [7:0]        out_sr_ff, nxt_out_sr;
    logic [2:0]        out_cnt_ff, nxt_out_cnt;
    logic              sent_ff, nxt_sent;
    logic              cfg_rd_ff, nxt_cfg_rd;
    logic              is_read_ff, nxt_is_read;
    logic [7:0]        cfg_ff, nxt_cfg, pend_cfg_ff, nxt_pend_cfg;
    logic [3:0]        sio_out_ff, nxt_sio_out, sio_oe_ff, nxt_sio_oe;
    logic              mem_we;
    logic [7:0]        mem_wdata;
    logic              rise, fall, cs_hi, hold, done;
    logic [4:0]        step;
    logic [23:0]       sh;
    logic [7:0]        byte_v;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] bits_per_clk(ssmc_width_t w);
        case (w)
            SSMC_W2: bits_per_clk = 5'h02;
            SSMC_W4: bits_per_clk = 5'h04;
            default: bits_per_clk = 5'h01;
        endcase
    endfunction

    function automatic logic [23:0] shift_in(logic [23:0] sr, ssmc_width_t w,
                                             logic [3:0] d);
        case (w)
            SSMC_W2: shift_in = {sr[21:0], d[1:0]}; // R06
            SSMC_W4: shift_in = {sr[19:0], d};      // R07
            default: shift_in = {sr[22:0], d[0]};   // R12
        endcase
    endfunction

    function automatic logic [3:0] drive_bits(logic [7:0] b, ssmc_width_t w);
        case (w)
            SSMC_W2: drive_bits = {2'h0, b[7:6]};
            SSMC_W4: drive_bits = b[7:4];
            default: drive_bits = {2'h0, b[7], 1'h0};
        endcase
    endfunction

    function automatic logic [3:0] drive_mask(ssmc_width_t w);
        case (w)
            SSMC_W2: drive_mask = 4'h3;
            SSMC_W4: drive_mask = 4'hf;
            default: drive_mask = 4'h2;
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] next_addr(logic [ADDR_W-1:0] a,
                                                    logic [1:0] m);
        if (m == SSMC_MODE_PAGE)
            next_addr = {a[ADDR_W-1:SSMC_PAGE_BITS],
                         SSMC_PAGE_BITS'(a[SSMC_PAGE_BITS-1:0] + 1'b1)}; // R13
        else
            next_addr = ADDR_W'(a + 1'b1); // R13
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; stage three only serves edge detection
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_s1_ff <= '{cs_n: 1'b1, sck: 1'b0, sio: 4'hf};
            pin_s2_ff <= '{cs_n: 1'b1, sck: 1'b0, sio: 4'hf};
            pin_s3_ff <= '{cs_n: 1'b1, sck: 1'b0, sio: 4'hf};
        end
        else
        begin
            pin_s1_ff <= '{cs_n: cs_n, sck: sck, sio: sio_in};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        rise           = pin_s2_ff.sck & ~pin_s3_ff.sck;
        fall           = ~pin_s2_ff.sck & pin_s3_ff.sck;
        cs_hi          = pin_s2_ff.cs_n;
        hold           = (width_ff != SSMC_W4) & ~pin_s2_ff.sio[3]; // R15
        step           = bits_per_clk(width_ff);
        sh             = shift_in(in_sr_ff, width_ff, pin_s2_ff.sio);
        done           = 5'(cnt_ff + step) == SSMC_DATA_BITS;
        byte_v         = cfg_rd_ff ? cfg_ff : mem[addr_ff];
        nxt_state      = state_ff;
        nxt_width      = width_ff;
        nxt_pend_width = pend_width_ff;
        nxt_cnt        = cnt_ff;
        nxt_in_sr      = in_sr_ff;
        nxt_addr       = addr_ff;
        nxt_out_sr     = out_sr_ff;
        nxt_out_cnt    = out_cnt_ff;
        nxt_sent       = sent_ff;
        nxt_cfg_rd     = cfg_rd_ff;
        nxt_is_read    = is_read_ff;
        nxt_cfg        = cfg_ff;
        nxt_pend_cfg   = pend_cfg_ff;
        nxt_sio_out    = sio_out_ff;
        mem_we         = 1'b0;
        mem_wdata      = sh[7:0];
        if (cs_hi)
        begin
            nxt_state = SSMC_IDLE;                                      // R14
            nxt_width = pend_width_ff;                                  // R16
            nxt_cfg   = pend_cfg_ff;                                    // R16
        end
        else if (state_ff == SSMC_IDLE)
        begin
            nxt_state   = SSMC_CMD;
            nxt_cnt     = 5'h00;
            nxt_sent    = 1'b0;
            nxt_cfg_rd  = 1'b0;
            nxt_out_cnt = 3'h0;
        end
        else if (!hold && rise && state_ff != SSMC_RDATA
                 && state_ff != SSMC_SKIP)
        begin
            nxt_in_sr = sh;
            nxt_cnt   = 5'(cnt_ff + step);
            case (state_ff)
                SSMC_CMD:
                    if (5'(cnt_ff + step) == SSMC_CMD_BITS)
                    begin
                        nxt_cnt   = 5'h00;
                        nxt_state = SSMC_SKIP;
                        case (sh[7:0])
                            SSMC_CMD_READ:
                            begin
                                nxt_state   = SSMC_ADDR;                // R12
                                nxt_is_read = 1'b1;
                            end
                            SSMC_CMD_WRITE:
                            begin
                                nxt_state   = SSMC_ADDR;                // R12
                                nxt_is_read = 1'b0;
                            end
                            SSMC_CMD_RD_CFG:
                            begin
                                nxt_state  = SSMC_RDATA;                // R01
                                nxt_cfg_rd = 1'b1;
                            end
                            SSMC_CMD_WR_CFG:     nxt_state = SSMC_CFGW; // R05
                            SSMC_CMD_DUAL:       nxt_pend_width = SSMC_W2; // R06
                            SSMC_CMD_QUAD:       nxt_pend_width = SSMC_W4; // R07
                            SSMC_CMD_RST_WIDTH:  nxt_pend_width = SSMC_W1; // R08
                            default:             nxt_state = SSMC_SKIP;
                        endcase
                    end
                SSMC_ADDR:
                    if (5'(cnt_ff + step) == SSMC_ADDR_BITS)
                    begin
                        nxt_cnt  = 5'h00;
                        nxt_addr = sh[ADDR_W-1:0];                      // R12
                        if (!is_read_ff)
                            nxt_state = SSMC_WDATA;                     // R10
                        else if (width_ff == SSMC_W2)
                            nxt_state = SSMC_DUMMY;                     // R09
                        else
                            nxt_state = SSMC_RDATA;
                    end
                SSMC_DUMMY:
                    if (5'(cnt_ff + step) == SSMC_DUMMY_BITS)
                    begin
                        nxt_cnt   = 5'h00;
                        nxt_state = SSMC_RDATA;                         // R09
                    end
                SSMC_WDATA:
                    if (done)
                    begin
                        nxt_cnt  = 5'h00;
                        mem_we   = 1'b1;
                        nxt_addr = next_addr(addr_ff,
                                   cfg_ff[SSMC_MODE_MSB:SSMC_MODE_LSB]);
                        if (cfg_ff[SSMC_MODE_MSB:SSMC_MODE_LSB]
                            == SSMC_MODE_BYTE)
                            nxt_state = SSMC_SKIP;                      // R02
                    end
                SSMC_CFGW:
                    if (done)
                    begin
                        nxt_pend_cfg = {sh[SSMC_MODE_MSB:SSMC_MODE_LSB],
                                        SSMC_CFG_RSVD};                 // R05
                        nxt_state    = SSMC_SKIP;
                    end
                default: nxt_state = SSMC_SKIP;
            endcase
        end
        else if (!hold && fall && state_ff == SSMC_RDATA)
        begin
            if (out_cnt_ff == 3'h0)
            begin
                if (sent_ff && !cfg_rd_ff && cfg_ff[SSMC_MODE_MSB:SSMC_MODE_LSB]
                    == SSMC_MODE_BYTE)
                    nxt_state = SSMC_SKIP;                              // R02
                else
                begin
                    nxt_sent    = 1'b1;
                    nxt_sio_out = drive_bits(byte_v, width_ff);
                    nxt_out_sr  = 8'(byte_v << step);
                    nxt_out_cnt = 3'(step);
                    if (!cfg_rd_ff)
                        nxt_addr = next_addr(addr_ff,
                                   cfg_ff[SSMC_MODE_MSB:SSMC_MODE_LSB]);
                end
            end
            else
            begin
                nxt_sio_out = drive_bits(out_sr_ff, width_ff);
                nxt_out_sr  = 8'(out_sr_ff << step);
                nxt_out_cnt = 3'(out_cnt_ff + step);
            end
        end
        nxt_sio_oe = (nxt_state == SSMC_RDATA && nxt_sent && !hold)
                     ? drive_mask(width_ff) : 4'h0;                     // R15
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys)
    begin
        if (mem_we)
            mem[addr_ff] <= mem_wdata;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_ff      <= SSMC_IDLE;
            width_ff      <= SSMC_W1;
            pend_width_ff <= SSMC_W1;
            cnt_ff        <= 5'h00;
            in_sr_ff      <= 24'h000000;
            addr_ff       <= '0;
            out_sr_ff     <= 8'h00;
            out_cnt_ff    <= 3'h0;
            sent_ff       <= 1'b0;
            cfg_rd_ff     <= 1'b0;
            is_read_ff    <= 1'b0;
            cfg_ff        <= SSMC_CFG_RESET; // R03
            pend_cfg_ff   <= SSMC_CFG_RESET; // R03
            sio_out_ff    <= 4'h0;
            sio_oe_ff     <= 4'h0;
        end
        else
        begin
            state_ff      <= nxt_state;
            width_ff      <= nxt_width;
            pend_width_ff <= nxt_pend_width;
            cnt_ff        <= nxt_cnt;
            in_sr_ff      <= nxt_in_sr;
            addr_ff       <= nxt_addr;
            out_sr_ff     <= nxt_out_sr;
            out_cnt_ff    <= nxt_out_cnt;
            sent_ff       <= nxt_sent;
            cfg_rd_ff     <= nxt_cfg_rd;
            is_read_ff    <= nxt_is_read;
            cfg_ff        <= nxt_cfg;
            pend_cfg_ff   <= nxt_pend_cfg;
            sio_out_ff    <= nxt_sio_out;
            sio_oe_ff     <= nxt_sio_oe;
        end
    end

    assign sio_out = sio_out_ff;
    assign sio_oe  = sio_oe_ff;
endmodule

`default_nettype wire

// ---- tb/ssmc_monitor.sv ----
// pin-level assertion checker for the serial sram block
`timescale 1ns/100ps
`default_nettype none
module ssmc_monitor (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic [3:0] sio_in,
    input wire logic [3:0] sio_out,
    input wire logic [3:0] sio_oe
);
    logic       sck_ff;
    logic [7:0] rise_ff;
    logic [7:0] nxt_rise;
    // counts serial clock rises within the current frame
    always_comb
    begin
        nxt_rise = rise_ff;
        if (cs_n)
            nxt_rise = 8'h00;
        else if (sck && !sck_ff && rise_ff != 8'hff)
            nxt_rise = rise_ff + 8'h01;
    end
    always_ff @(posedge clk_sys)
    begin
        sck_ff  <= sck;
        rise_ff <= rst ? 8'h00 : nxt_rise;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_quiet; cs_n [*6] |-> sio_oe == 4'h0; endproperty
    a_quiet: assert property (p_quiet)
        else $error("lines driven while deselected");
    property p_release; $rose(cs_n) |-> ##[1:6] sio_oe == 4'h0; endproperty
    a_release: assert property (p_release)
        else $error("lines not released after deselect");
    property p_shape; sio_oe inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
    a_shape: assert property (p_shape)
        else $error("driven lines do not match any width");
    property p_out_hold; (sck && !cs_n) [*3] |-> $stable(sio_out); endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("output changed while clock high");
    property p_oe_hold; (sck && !cs_n) [*3] |-> $stable(sio_oe); endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("enable changed while clock high");
    property p_frame; $rose(|sio_oe) |-> !cs_n && $past(cs_n, 3) == 1'b0;
    endproperty
    a_frame: assert property (p_frame)
        else $error("lines driven outside a frame");
    property p_single; $rose(sio_oe == 4'h2) |-> rise_ff >= 8'h08; endproperty
    a_single: assert property (p_single)
        else $error("single output before command complete");
    property p_dual; $rose(sio_oe == 4'h3) |-> rise_ff >= 8'h04; endproperty
    a_dual: assert property (p_dual)
        else $error("dual output before command complete");
endmodule
bind ssmc_serial_sram ssmc_monitor mon_u (.clk_sys, .rst, .cs_n, .sck,
    .sio_in, .sio_out, .sio_oe);
`default_nettype wire

// ---- tb/ssmc_host_model.sv ----
// host controller model driving the serial sram pins
`timescale 1ns/100ps
`default_nettype none
module ssmc_host_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] sio_out,
    input  wire logic [3:0] sio_oe,
    output var  logic       cs_n,
    output var  logic       sck,
    output wire logic [3:0] sio_in
);
    logic [3:0] hd = 4'hf;
    logic [3:0] ho = 4'hf;
    logic [3:0] junk = 4'h5;
    logic [7:0] rx_byte;
    event       rx_ev;
    // released lines toggle so a stale level never passes for data
    assign sio_in = (sio_oe & sio_out)
                  | (~sio_oe & ((ho & hd) | (~ho & junk)));
    initial cs_n = 1'b1;
    initial sck = 1'b0;
    always @(negedge clk_sys) junk <= ~junk;
    task automatic start();
        @(negedge clk_sys);
        cs_n = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic stop();
        @(negedge clk_sys);
        sck = 1'b0;
        repeat (2) @(negedge clk_sys);
        cs_n = 1'b1;
        ho = 4'hf;
        hd = 4'hf;
        repeat (5) @(negedge clk_sys);
    endtask
    task automatic xfer(input logic [7:0] tx, input int w, input bit drv,
                        input bit chk);
        logic [7:0] rx;
        rx = 8'h00;
        for (int i = 0; i < 8 / w; i++)
        begin
            @(negedge clk_sys);
            sck = 1'b0;
            hd = (w == 1) ? {3'b111, tx[7 - i]} : (w == 2) ?
                 {2'b11, tx[7 - 2 * i -: 2]} : tx[7 - 4 * i -: 4];
            ho = (w == 4) ? {4{drv}} : (w == 2) ? {2'b11, {2{drv}}}
               : 4'b1101;
            repeat (4) @(negedge clk_sys);
            sck = 1'b1;
            repeat (3) @(negedge clk_sys);
            rx = (w == 1) ? {rx[6:0], sio_in[1]} : (w == 2) ?
                 {rx[5:0], sio_in[1:0]} : {rx[3:0], sio_in};
        end
        if (chk)
        begin
            rx_byte = rx;
            -> rx_ev;
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/serial_sram_mode_control_tb.sv ----
// self-checking bench of the serial sram mode control block
`timescale 1ns/100ps
`default_nettype none
module serial_sram_mode_control_tb;
    import ssmc_pkg::*;
    logic       clk_sys;
    logic       rst;
    wire logic  cs_n;
    wire logic  sck;
    wire logic [3:0] sio_in;
    wire logic [3:0] sio_out;
    wire logic [3:0] sio_oe;
    logic [7:0] exp_q[$];
    int         failures;
    int         checked;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [1:0] modes [3] = '{SSMC_MODE_BYTE, SSMC_MODE_PAGE, SSMC_MODE_SEQ};
    ssmc_host_model host_u (.clk_sys, .sio_out, .sio_oe, .cs_n, .sck,
        .sio_in);
    ssmc_serial_sram #(.ADDR_W(SSMC_ADDR_W)) dut_u (.clk_sys, .rst, .cs_n,
        .sck, .sio_in, .sio_out, .sio_oe);
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    initial
    forever
    begin
        @(host_u.rx_ev);
        check_byte(host_u.rx_byte, exp_q.size() != 0 ? exp_q.pop_front()
                   : ~host_u.rx_byte);
    end
    task automatic width(input logic [7:0] c, input int w);
        host_u.start();
        host_u.xfer(c, w, 1'b1, 1'b0);
        host_u.stop();
    endtask
    task automatic cfg(input bit wr, input logic [7:0] v, input int w);
        host_u.start();
        host_u.xfer(wr ? SSMC_CMD_WR_CFG : SSMC_CMD_RD_CFG, w, 1'b1, 1'b0);
        repeat (wr ? 1 : 2)
        begin
            if (!wr)
                exp_q.push_back(v);
            host_u.xfer(v, w, wr, !wr);
        end
        host_u.stop();
    endtask
    task automatic mem(input bit rd, input int w, input logic [15:0] a,
                       input logic [7:0] b0, input logic [7:0] b1, input int n);
        host_u.start();
        host_u.xfer(rd ? SSMC_CMD_READ : SSMC_CMD_WRITE, w, 1'b1, 1'b0);
        host_u.xfer(8'($urandom), w, 1'b1, 1'b0);
        host_u.xfer(a[15:8], w, 1'b1, 1'b0);
        host_u.xfer(a[7:0], w, 1'b1, 1'b0);
        if (rd && w == 2)
            host_u.xfer(8'h00, w, 1'b0, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            if (rd)
                exp_q.push_back(i != 0 ? b1 : b0);
            host_u.xfer(i != 0 ? b1 : b0, w, !rd, rd);
        end
        host_u.stop();
    endtask
    initial
    begin
        rst = 1'b1;
        failures = 0;
        checked = 0;
        void'($urandom(32'h82ba));
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        cfg(1'b0, SSMC_CFG_RESET, 1);
        width(SSMC_CMD_RST_WIDTH, 1);
        foreach (modes[i])
        begin
            cfg(1'b1, {modes[i], SSMC_CFG_RSVD}, 1);
            cfg(1'b0, {modes[i], SSMC_CFG_RSVD}, 1);
        end
        mem(1'b0, 1, 16'hffff, d0, d1, 2);
        mem(1'b1, 1, 16'h0000, d1, d1, 1);
        cfg(1'b1, {SSMC_MODE_PAGE, SSMC_CFG_RSVD}, 1);
        mem(1'b0, 1, 16'h123f, d1, d0, 2);
        cfg(1'b1, SSMC_CFG_RESET, 1);
        mem(1'b1, 1, 16'h1220, d0, d0, 1);
        // byte mode: the second write byte must not reach 0000
        cfg(1'b1, {SSMC_MODE_BYTE, SSMC_CFG_RSVD}, 1);
        mem(1'b0, 1, 16'hffff, d1, d0, 2);
        mem(1'b1, 1, 16'hffff, d1, d1, 1);
        cfg(1'b1, SSMC_CFG_RESET, 1);
        mem(1'b1, 1, 16'hffff, d1, d1, 2);
        width(SSMC_CMD_DUAL, 1);
        cfg(1'b0, SSMC_CFG_RESET, 2);
        mem(1'b0, 2, 16'h0a5c, d0, d1, 2);
        mem(1'b1, 2, 16'h0a5c, d0, d1, 2);
        width(SSMC_CMD_RST_WIDTH, 2);
        cfg(1'b0, SSMC_CFG_RESET, 1);
        width(SSMC_CMD_QUAD, 1);
        mem(1'b0, 4, 16'h7777, 8'h35, d1, 2);
        mem(1'b1, 4, 16'h7777, 8'h35, d1, 2);
        cfg(1'b0, SSMC_CFG_RESET, 4);
        width(SSMC_CMD_RST_WIDTH, 4);
        cfg(1'b0, SSMC_CFG_RESET, 1);
        test_done();
    end
    // the sequence needs about 0.6 ms of serial traffic
    initial
    begin
        #5000000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
